// ---- pwa_pkg.sv ----
// Constants, register map and types for the power event wake aggregator.
package pwa_pkg;
  // Configuration space indices.
  localparam logic [7:0] PWA_CFG_BASE_HI = 8'h60;
  localparam logic [7:0] PWA_CFG_BASE_LO = 8'h61;
  localparam logic [7:0] PWA_CFG_SLOW_CLOCK = 8'hf0;
  localparam int PWA_SLOW_PRESENT_BIT = 0;
  localparam int PWA_KEY_MATCH_DISABLE_BIT = 1;
  localparam logic [7:0] PWA_SLOW_CLOCK_RESET = 8'h00;
  localparam logic [15:0] PWA_RT_BASE_RESET = 16'h0000;
  // Runtime block: 128 bytes, base aligned to 128.
  localparam int PWA_RT_ADDR_BITS = 7;
  localparam logic [6:0] PWA_RT_CTRL = 7'h00;
  localparam logic [6:0] PWA_RT_STS_BASE = 7'h01;
  localparam logic [6:0] PWA_RT_EN_BASE = 7'h09;
  localparam logic [6:0] PWA_RT_GPIO_POL_BASE = 7'h10;
  localparam logic [6:0] PWA_RT_GPIO_EITHER_EDGE_TRIGGER_BASE = 7'h18;
  localparam logic [6:0] PWA_RT_EDGE_SEL = 7'h21;
  localparam logic [6:0] PWA_RT_SHARED_PIN_CTRL = 7'h24;
  localparam logic [6:0] PWA_RT_WAKE_KEY_CODE = 7'h5f;
  localparam int PWA_CTRL_SUMMARY_BIT = 0;
  localparam int PWA_CTRL_GLOBAL_EN_BIT = 1;
  localparam int PWA_EDGE_A_BOTH_BIT = 0;
  localparam int PWA_EDGE_B_BOTH_BIT = 1;
  localparam int PWA_EDGE_A_POL_BIT = 2;
  localparam int PWA_PIN_POL_BIT = 1;
  localparam int PWA_PIN_OD_BIT = 7;
  localparam logic [7:0] PWA_PIN_CTRL_RESET = 8'h80;
  localparam logic [7:0] PWA_KEY_CODE_RESET = 8'h00;
  // Status/enable pairs and bit layout.
  localparam int PWA_NUM_PAIRS = 7;
  localparam int PWA_GPIO_GROUPS = 5;
  localparam int PWA_GPIO_COUNT = 38;
  localparam int PWA_FIRST_RING_A = 0;
  localparam int PWA_FIRST_RING_B = 1;
  localparam int PWA_FIRST_KBD = 2;
  localparam int PWA_FIRST_MOUSE = 3;
  localparam int PWA_FIRST_FAN = 4;
  localparam int PWA_FIRST_KEY = 5;
  localparam int PWA_FIRST_WDT = 6;
  localparam int PWA_DEV_PAIR = 6;
  localparam int PWA_KBC_PAIR = 7;
  localparam int PWA_KBC_A_BIT = 6;
  localparam int PWA_KBC_B_BIT = 7;
  // Slow clock derived from the system clock.
  localparam int PWA_SYS_CLK_HZ = 100_000_000;
  localparam int PWA_SLOW_CLK_HZ = 32_768;
  localparam int PWA_SLOW_DIV_CYCLES = PWA_SYS_CLK_HZ / PWA_SLOW_CLK_HZ;
  localparam logic [3:0] PWA_KEY_FRAME_BITS = 4'hb;
  typedef enum logic [1:0] {
    PWA_KEY_IDLE = 2'b00,
    PWA_KEY_SHIFT = 2'b01,
    PWA_KEY_CHECK = 2'b10
  } pwa_key_state_e;
endpackage

// ---- pwa_wake_aggregator.sv ----
// Wake event aggregator with specific-key detector and wake request pin driver.
// Operation
// R1 - Ring, keyboard, mouse, key match, device, watchdog, GPIO, fan events request wake.
// R2 - Software selects wake pin polarity and open-drain or push-pull via bit 7.
// R3 - After reset the wake pin is active low, open drain.
// R4 - Global enable clear means the wake request is never asserted.
// R5 - With global enable set, any enabled source event asserts the wake request.
// R6 - Summary status sets on source events whatever the global enable.
// R7 - Summary is OR over sources of status AND enable.
// R8 - Summary stays set until every pending enabled status is cleared by software.
// R9 - GPIO status sets on rising edge, falling edge when polarity inverted.
// R10 - Either-edge option sets the GPIO status on both edges.
// R11 - GPIO status clears on write of one; zero leaves it.
// R12 - Edge select at 21h picks falling or both edges; pin A has polarity.
// R13 - Both-edge port pin events assert and hold until status cleared.
// R14 - Port pin status clears by writing one; its SMI drops with it.
// R15 - Runtime registers sit in I/O space at base from config 0x60, 0x61.
// R16 - Pairs 2,3,4,5,7 GPIO; pair 6 device interrupts; pair 1 pins and functions.
// R17 - Received keyboard bytes compare with code at 0x5F, reset only at power-on.
// R18 - Key match sets first status bit 5, wakes only with enable bit 5.
// R19 - Keyboard frames: start 0, eight data LSB first, odd parity, stop 1.
// R20 - Detector uses external slow clock or one derived internally; 0xF0 bit 0 picks.
// R21 - Without main power the detector needs the external slow clock.
// R22 - Config 0xF0 bit 1 set stops the detector clock.
// R23 - Malformed frames are discarded without any effect.
`timescale 1ns/1ns
module pwa_wake_aggregator #(
  parameter int SLOW_DIV_CYCLES = pwa_pkg::PWA_SLOW_DIV_CYCLES
) (
  // Clock and standby power-on reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Runtime I/O space access.
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  // Configuration space access.
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  // Wake sources.
  input wire logic ring_indicator_a_n,
  input wire logic ring_indicator_b_n,
  input wire logic kbd_data,
  input wire logic kbd_clk,
  input wire logic mouse_data,
  input wire logic fan_tach_event,
  input wire logic watchdog_expired,
  input wire logic [7:0] device_irq,
  input wire logic [pwa_pkg::PWA_GPIO_COUNT-1:0] gpio_in,
  input wire logic kbc_port_pin_a,
  input wire logic kbc_port_pin_b,
  // Power and slow clock.
  input wire logic main_power,
  input wire logic ext_slow_clk,
  // Wake request pin and port pin SMI.
  output logic wake_request_out,
  output logic wake_request_oe_n,
  output logic kbc_pin_smi
);
  import pwa_pkg::*;

  function automatic logic [6:0] rt_off(input logic [6:0] base, input int idx);
    rt_off = 7'(int'(base) + idx);
  endfunction

  logic [15:0] rt_base;
  logic [7:0] slow_clock_config, edge_sel, shared_wake_pin_ctrl, wake_key_code;
  logic [7:0] sts [1:7], en [1:7], evt [1:7];
  logic [7:0] gpio_pol [0:4], gpio_either_edge_trigger [0:4];
  logic global_wake_enable, summary_wake_status, wake_active, pending, summary_clr, rt_hit, rt_wr;
  logic [6:0] rt_off_q;
  logic ring_a_prev, ring_b_prev, kdata_prev, mdata_prev, fan_prev, wdt_prev, pin_a_prev, pin_b_prev;
  logic [7:0] dev_prev;
  logic [PWA_GPIO_COUNT-1:0] gpio_prev;
  logic pin_a_eff, ext_prev, div_tick, slow_tick, kclk_prev, key_match;
  logic [11:0] div_cnt;
  logic [9:0] key_shift;
  logic [3:0] key_count;
  pwa_key_state_e key_state, next_key_state;

  assign rt_hit = io_addr[15:PWA_RT_ADDR_BITS] == rt_base[15:PWA_RT_ADDR_BITS]; // R15
  assign rt_off_q = io_addr[PWA_RT_ADDR_BITS-1:0];
  assign rt_wr = io_wr && rt_hit;
  assign pin_a_eff = kbc_port_pin_a ^ edge_sel[PWA_EDGE_A_POL_BIT];

  // Configuration registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rt_base <= PWA_RT_BASE_RESET;
      slow_clock_config <= PWA_SLOW_CLOCK_RESET;
    end else if (cfg_wr) begin
      if (cfg_index == PWA_CFG_BASE_HI) rt_base[15:8] <= cfg_wdata;
      if (cfg_index == PWA_CFG_BASE_LO) rt_base[7:0] <= {cfg_wdata[7], 7'h00};
      if (cfg_index == PWA_CFG_SLOW_CLOCK) slow_clock_config <= {6'h00, cfg_wdata[1:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_index)
        PWA_CFG_BASE_HI: cfg_rdata <= rt_base[15:8];
        PWA_CFG_BASE_LO: cfg_rdata <= rt_base[7:0];
        PWA_CFG_SLOW_CLOCK: cfg_rdata <= slow_clock_config;
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

  // Runtime control registers. The key code lives on standby power and is only reset here.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      global_wake_enable <= 1'b0;
      edge_sel <= 8'h00;
      shared_wake_pin_ctrl <= PWA_PIN_CTRL_RESET; // R3
      wake_key_code <= PWA_KEY_CODE_RESET; // R17
      for (int n = 1; n <= PWA_NUM_PAIRS; n++) en[n] <= 8'h00;
      for (int g = 0; g < PWA_GPIO_GROUPS; g++) begin
        gpio_pol[g] <= 8'h00;
        gpio_either_edge_trigger[g] <= 8'h00;
      end
    end else if (rt_wr) begin
      if (rt_off_q == PWA_RT_CTRL) global_wake_enable <= io_wdata[PWA_CTRL_GLOBAL_EN_BIT];
      if (rt_off_q == PWA_RT_EDGE_SEL) edge_sel <= {5'h00, io_wdata[2:0]}; // R12
      if (rt_off_q == PWA_RT_SHARED_PIN_CTRL) shared_wake_pin_ctrl <= io_wdata; // R2
      if (rt_off_q == PWA_RT_WAKE_KEY_CODE) wake_key_code <= io_wdata; // R17
      for (int n = 1; n <= PWA_NUM_PAIRS; n++) begin
        if (rt_off_q == rt_off(PWA_RT_EN_BASE, n - 1)) en[n] <= io_wdata;
      end
      for (int g = 0; g < PWA_GPIO_GROUPS; g++) begin
        if (rt_off_q == rt_off(PWA_RT_GPIO_POL_BASE, g)) gpio_pol[g] <= io_wdata;
        if (rt_off_q == rt_off(PWA_RT_GPIO_EITHER_EDGE_TRIGGER_BASE, g)) gpio_either_edge_trigger[g] <= io_wdata;
      end
    end
  end

  // Previous input levels for edge detection.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {ring_a_prev, ring_b_prev} <= 2'b11;
      {kdata_prev, mdata_prev, fan_prev, wdt_prev} <= 4'h0;
      {pin_a_prev, pin_b_prev} <= 2'b00;
      dev_prev <= 8'h00;
      gpio_prev <= '0;
    end else begin
      {ring_a_prev, ring_b_prev} <= {ring_indicator_a_n, ring_indicator_b_n};
      {kdata_prev, mdata_prev, fan_prev, wdt_prev} <= {kbd_data, mouse_data, fan_tach_event, watchdog_expired};
      {pin_a_prev, pin_b_prev} <= {pin_a_eff, kbc_port_pin_b};
      dev_prev <= device_irq;
      gpio_prev <= gpio_in;
    end
  end

  // Source events, grouped by status/enable pair.
  always_comb begin
    for (int n = 1; n <= PWA_NUM_PAIRS; n++) evt[n] = 8'h00;
    evt[1][PWA_FIRST_RING_A] = ring_a_prev && !ring_indicator_a_n; // R1
    evt[1][PWA_FIRST_RING_B] = ring_b_prev && !ring_indicator_b_n; // R1
    evt[1][PWA_FIRST_KBD] = kdata_prev && !kbd_data; // R1
    evt[1][PWA_FIRST_MOUSE] = mdata_prev && !mouse_data; // R1
    evt[1][PWA_FIRST_FAN] = !fan_prev && fan_tach_event; // R1
    evt[1][PWA_FIRST_KEY] = key_match; // R18
    evt[1][PWA_FIRST_WDT] = !wdt_prev && watchdog_expired; // R1
    evt[PWA_DEV_PAIR] = device_irq & ~dev_prev; // R16
    for (int i = 0; i < PWA_GPIO_COUNT; i++) begin
      // Groups 0..3 feed pairs 2..5, group 4 feeds the low bits of pair 7.
      if (gpio_either_edge_trigger[i / 8][i % 8]) begin
        evt[(i / 8 == 4) ? 7 : i / 8 + 2][i % 8] = gpio_prev[i] ^ gpio_in[i]; // R10
      end else if (gpio_pol[i / 8][i % 8]) begin
        evt[(i / 8 == 4) ? 7 : i / 8 + 2][i % 8] = gpio_prev[i] && !gpio_in[i]; // R9
      end else begin
        evt[(i / 8 == 4) ? 7 : i / 8 + 2][i % 8] = !gpio_prev[i] && gpio_in[i]; // R9
      end
    end
    evt[PWA_KBC_PAIR][PWA_KBC_A_BIT] = edge_sel[PWA_EDGE_A_BOTH_BIT] ? (pin_a_prev ^ pin_a_eff)
                                                                     : (pin_a_prev && !pin_a_eff); // R12
    evt[PWA_KBC_PAIR][PWA_KBC_B_BIT] = edge_sel[PWA_EDGE_B_BOTH_BIT] ? (pin_b_prev ^ kbc_port_pin_b)
                                                                     : (pin_b_prev && !kbc_port_pin_b); // R12
  end

  // Sticky status; a new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int n = 1; n <= PWA_NUM_PAIRS; n++) sts[n] <= 8'h00;
    end else begin
      for (int n = 1; n <= PWA_NUM_PAIRS; n++) begin
        if (rt_wr && rt_off_q == rt_off(PWA_RT_STS_BASE, n - 1)) begin
          sts[n] <= (sts[n] & ~io_wdata) | evt[n]; // R11 R13 R14
        end else begin
          sts[n] <= sts[n] | evt[n]; // R13
        end
      end
    end
  end

  always_comb begin
    pending = 1'b0;
    for (int n = 1; n <= PWA_NUM_PAIRS; n++) pending = pending | (|(sts[n] & en[n])); // R7
  end

  // Software may only clear the summary once nothing enabled is pending.
  assign summary_clr = rt_wr && rt_off_q == PWA_RT_CTRL && io_wdata[PWA_CTRL_SUMMARY_BIT] && !pending;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      summary_wake_status <= 1'b0;
    end else if (pending) begin
      summary_wake_status <= 1'b1; // R6
    end else if (summary_clr) begin
      summary_wake_status <= 1'b0; // R8
    end
  end

  // Wake pin drive. Open drain can only pull low, so active high open drain releases when asserted.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_active <= 1'b0;
      wake_request_out <= 1'b0;
      wake_request_oe_n <= 1'b1;
      kbc_pin_smi <= 1'b0;
    end else begin
      wake_active <= global_wake_enable && summary_wake_status; // R4 R5
      kbc_pin_smi <= |sts[PWA_KBC_PAIR][PWA_KBC_B_BIT:PWA_KBC_A_BIT]; // R14
      if (shared_wake_pin_ctrl[PWA_PIN_OD_BIT]) begin
        wake_request_out <= 1'b0; // R2
        wake_request_oe_n <= !((global_wake_enable && summary_wake_status) ^ shared_wake_pin_ctrl[PWA_PIN_POL_BIT]);
      end else begin
        wake_request_oe_n <= 1'b0; // R2
        wake_request_out <= (global_wake_enable && summary_wake_status) == shared_wake_pin_ctrl[PWA_PIN_POL_BIT];
      end
    end
  end

  // Slow clock tick: external clock rising edge, or internal divider while main power is up.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_prev <= 1'b0;
      div_cnt <= 12'h000;
    end else begin
      ext_prev <= ext_slow_clk;
      if (!main_power || div_tick) begin
        div_cnt <= 12'h000;
      end else begin
        div_cnt <= div_cnt + 12'h001;
      end
    end
  end

  assign div_tick = main_power && div_cnt == 12'(SLOW_DIV_CYCLES - 1);
  assign slow_tick = !slow_clock_config[PWA_KEY_MATCH_DISABLE_BIT] // R22
                  && (slow_clock_config[PWA_SLOW_PRESENT_BIT] ? (ext_slow_clk && !ext_prev) : div_tick); // R20 R21

  // Frame receiver sampled on the slow tick; data is taken on the keyboard clock falling edge.
  always_comb begin
    next_key_state = key_state;
    case (key_state)
      PWA_KEY_IDLE: begin
        if (slow_tick && kclk_prev && !kbd_clk && !kbd_data) next_key_state = PWA_KEY_SHIFT; // R19
      end
      PWA_KEY_SHIFT: begin
        if (slow_tick && kclk_prev && !kbd_clk && key_count == PWA_KEY_FRAME_BITS - 4'h1) begin
          next_key_state = PWA_KEY_CHECK;
        end
      end
      PWA_KEY_CHECK: next_key_state = PWA_KEY_IDLE;
      default: next_key_state = PWA_KEY_IDLE;
    endcase
    if (slow_clock_config[PWA_KEY_MATCH_DISABLE_BIT]) next_key_state = PWA_KEY_IDLE; // R22
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      key_state <= PWA_KEY_IDLE;
      kclk_prev <= 1'b1;
      key_shift <= 10'h000;
      key_count <= 4'h0;
      key_match <= 1'b0;
    end else begin
      key_state <= next_key_state;
      if (slow_tick) kclk_prev <= kbd_clk;
      if (key_state == PWA_KEY_IDLE) key_count <= 4'h1;
      if (key_state == PWA_KEY_SHIFT && slow_tick && kclk_prev && !kbd_clk) begin
        key_shift <= {kbd_data, key_shift[9:1]}; // R19
        key_count <= key_count + 4'h1;
      end
      // Shift holds {stop, parity, data}; a bad frame just falls back to idle.
      key_match <= key_state == PWA_KEY_CHECK && !slow_clock_config[PWA_KEY_MATCH_DISABLE_BIT]
                && key_shift[9] && ^key_shift[8:0] && key_shift[7:0] == wake_key_code; // R17 R23
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= 8'h00;
      if (rt_hit) begin
        if (rt_off_q == PWA_RT_CTRL) io_rdata <= {6'h00, global_wake_enable, summary_wake_status};
        if (rt_off_q == PWA_RT_EDGE_SEL) io_rdata <= edge_sel;
        if (rt_off_q == PWA_RT_SHARED_PIN_CTRL) io_rdata <= shared_wake_pin_ctrl;
        if (rt_off_q == PWA_RT_WAKE_KEY_CODE) io_rdata <= wake_key_code;
        for (int n = 1; n <= PWA_NUM_PAIRS; n++) begin
          if (rt_off_q == rt_off(PWA_RT_STS_BASE, n - 1)) io_rdata <= sts[n];
          if (rt_off_q == rt_off(PWA_RT_EN_BASE, n - 1)) io_rdata <= en[n];
        end
        for (int g = 0; g < PWA_GPIO_GROUPS; g++) begin
          if (rt_off_q == rt_off(PWA_RT_GPIO_POL_BASE, g)) io_rdata <= gpio_pol[g];
          if (rt_off_q == rt_off(PWA_RT_GPIO_EITHER_EDGE_TRIGGER_BASE, g)) io_rdata <= gpio_either_edge_trigger[g];
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_global_gate;
    !global_wake_enable |=> !wake_active && (wake_request_oe_n || $past(shared_wake_pin_ctrl) != PWA_PIN_CTRL_RESET);
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("wake asserted with global enable clear"); // R4
  property p_enabled_wakes;
    global_wake_enable && pending && !(rt_wr && rt_off_q == PWA_RT_CTRL) |=> ##1 wake_active;
  endproperty
  a_enabled_wakes: assert property (p_enabled_wakes) else $error("enabled event did not wake"); // R5
  property p_summary_set;
    pending |=> summary_wake_status;
  endproperty
  a_summary_set: assert property (p_summary_set) else $error("summary not set by pending event"); // R6
  property p_summary_hold;
    summary_wake_status && !summary_clr |=> summary_wake_status;
  endproperty
  a_summary_hold: assert property (p_summary_hold) else $error("summary dropped without clear"); // R8
  property p_key_status;
    key_match |=> sts[1][PWA_FIRST_KEY];
  endproperty
  a_key_status: assert property (p_key_status) else $error("key match did not set status"); // R18
  property p_gpio_clear;
    rt_wr && rt_off_q == PWA_RT_STS_BASE + 7'h01 && io_wdata[0] && !evt[2][0] |=> !sts[2][0];
  endproperty
  a_gpio_clear: assert property (p_gpio_clear) else $error("gpio status not cleared by one"); // R11
  property p_pin_od_low;
    wake_active && shared_wake_pin_ctrl[PWA_PIN_OD_BIT] && !shared_wake_pin_ctrl[PWA_PIN_POL_BIT]
      && $stable(shared_wake_pin_ctrl) |-> !wake_request_oe_n && !wake_request_out;
  endproperty
  a_pin_od_low: assert property (p_pin_od_low) else $error("open drain low pin not driving"); // R2
  property p_disabled_no_match;
    $past(slow_clock_config[PWA_KEY_MATCH_DISABLE_BIT]) |-> !key_match;
  endproperty
  a_disabled_no_match: assert property (p_disabled_no_match) else $error("detector matched while off"); // R22
  property p_no_clock_no_tick;
    !main_power && !slow_clock_config[PWA_SLOW_PRESENT_BIT] |-> !slow_tick;
  endproperty
  a_no_clock_no_tick: assert property (p_no_clock_no_tick) else $error("tick without any slow clock"); // R21
  property p_kbc_smi_drop;
    sts[PWA_KBC_PAIR][PWA_KBC_B_BIT:PWA_KBC_A_BIT] == 2'b00 |=> !kbc_pin_smi;
  endproperty
  a_kbc_smi_drop: assert property (p_kbc_smi_drop) else $error("port pin SMI held after clear"); // R14

  c_key_match: cover property (key_match);
  c_wake: cover property (wake_active ##1 !wake_active);
  c_both_edges: cover property (edge_sel[PWA_EDGE_B_BOTH_BIT] && evt[PWA_KBC_PAIR][PWA_KBC_B_BIT]);
  c_summary_clear: cover property (summary_clr);
endmodule

// ---- pwa_chipset_wake_model.sv ----
// Chipset wake input model: resolves the shared wake wire with its pull-up.
`timescale 1ns/1ns
module pwa_chipset_wake_model (
  // Pin drive from the block.
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Resolved wire level and wake seen by the chipset, high while the wire is low.
  output logic wire_level,
  output logic wake_seen
);
  // A released pin goes to the pull-up level, never to the last driven value.
  assign wire_level = pin_oe_n ? 1'b1 : pin_out;
  assign wake_seen = ~wire_level;
endmodule

// ---- pwa_wake_aggregator_test.sv ----
// Self-checking testbench for the power event wake aggregator.
`timescale 1ns/1ns
module pwa_wake_aggregator_test;
  import pwa_pkg::*;
  localparam logic [15:0] RT_BASE = 16'h1000;
  logic sys_clk, reset, io_wr, io_rd, cfg_wr, cfg_rd, ring_a_n, ring_b_n, kbd_data, kbd_clk, mouse_data;
  logic fan_ev, wdt_ev, pin_a, pin_b, main_power, ext_slow_clk, wake_out, wake_oe_n, smi, wire_level, wake_seen;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, cfg_index, cfg_wdata, cfg_rdata, device_irq;
  logic [PWA_GPIO_COUNT-1:0] gpio_in;
  int err_count = 0;
  int total_checks = 0;
  pwa_wake_aggregator #(.SLOW_DIV_CYCLES(4)) i_pwa_wake_aggregator (.sys_clk(sys_clk), .reset(reset),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .ring_indicator_a_n(ring_a_n), .ring_indicator_b_n(ring_b_n), .kbd_data(kbd_data), .kbd_clk(kbd_clk),
    .mouse_data(mouse_data), .fan_tach_event(fan_ev), .watchdog_expired(wdt_ev), .device_irq(device_irq),
    .gpio_in(gpio_in), .kbc_port_pin_a(pin_a), .kbc_port_pin_b(pin_b), .main_power(main_power),
    .ext_slow_clk(ext_slow_clk), .wake_request_out(wake_out), .wake_request_oe_n(wake_oe_n),
    .kbc_pin_smi(smi));
  pwa_chipset_wake_model i_pwa_chipset_wake_model (.pin_out(wake_out), .pin_oe_n(wake_oe_n),
    .wire_level(wire_level), .wake_seen(wake_seen));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Free-running external slow clock, four system clocks per period.
  initial begin
    ext_slow_clk = 1'b0;
    forever begin
      tick(2);
      ext_slow_clk = ~ext_slow_clk;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Pin as {drive value, output enable low-active}.
  task automatic pin_chk(input logic [1:0] exp);
    chk({6'h00, wake_out, wake_oe_n}, {6'h00, exp}, "wake pin");
  endtask
  // Strobes drop and one edge passes, so back-to-back calls never re-raise in one step.
  task automatic io_w(input logic [6:0] off, input logic [7:0] d);
    io_addr = RT_BASE | {9'h000, off};
    io_wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask
  task automatic io_chk(input logic [6:0] off, input logic [7:0] mask, input logic [7:0] exp);
    io_addr = RT_BASE | {9'h000, off};
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    tick(1);
    chk(io_rdata & mask, exp, "runtime read");
  endtask
  task automatic cfg_w(input logic [7:0] idx, input logic [7:0] d);
    cfg_index = idx;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask
  task automatic cfg_chk(input logic [7:0] idx, input logic [7:0] exp);
    cfg_index = idx;
    cfg_rd = 1'b1;
    tick(1);
    cfg_rd = 1'b0;
    tick(1);
    chk(cfg_rdata, exp, "config read");
  endtask
  // Each bit is held over many slow ticks so the detector sees every clock fall.
  task automatic send_frame(input logic [7:0] d, input logic good);
    logic [10:0] f;
    f = {1'b1, good ? ~^d : ^d, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      kbd_data = f[i];
      tick(20);
      kbd_clk = 1'b0;
      tick(40);
      kbd_clk = 1'b1;
      tick(20);
    end
    tick(40);
  endtask
  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask
  initial begin
    #1_000_000;
    err_count++;
    complete_run();
  end
  initial begin
    {io_wr, io_rd, cfg_wr, cfg_rd, fan_ev, wdt_ev} = '0;
    {ring_a_n, ring_b_n, kbd_data, kbd_clk, mouse_data, pin_a, pin_b, main_power} = '1;
    {io_addr, io_wdata, cfg_index, cfg_wdata, device_irq} = '0;
    gpio_in = '0;
    reset = 1'b1;
    tick(12);
    reset = 1'b0;
    pin_chk(2'b01);
    chk({7'h00, wire_level}, 8'h01, "wire idle");
    cfg_w(PWA_CFG_BASE_HI, 8'h10);
    cfg_w(PWA_CFG_BASE_LO, 8'h00);
    cfg_w(PWA_CFG_BASE_LO, 8'h7f);
    cfg_chk(PWA_CFG_BASE_LO, 8'h00);
    cfg_chk(PWA_CFG_BASE_HI, 8'h10);
    cfg_chk(PWA_CFG_SLOW_CLOCK, 8'h00);
    io_chk(PWA_RT_SHARED_PIN_CTRL, 8'hff, 8'h80);
    io_chk(PWA_RT_WAKE_KEY_CODE, 8'hff, 8'h00);
    io_chk(7'h40, 8'hff, 8'h00);
    test_done("reset");
    io_w(7'h0a, 8'h01);
    gpio_in[0] = 1'b1;
    tick(4);
    pin_chk(2'b01);
    io_chk(7'h02, 8'h01, 8'h01);
    io_chk(PWA_RT_CTRL, 8'h01, 8'h01);
    io_w(PWA_RT_CTRL, 8'h02);
    tick(4);
    pin_chk(2'b00);
    chk({7'h00, wake_seen}, 8'h01, "chipset wake");
    io_w(PWA_RT_CTRL, 8'h03);
    io_chk(PWA_RT_CTRL, 8'h01, 8'h01);
    io_w(7'h02, 8'h00);
    io_chk(7'h02, 8'h01, 8'h01);
    io_w(7'h02, 8'h01);
    io_chk(7'h02, 8'h01, 8'h00);
    io_chk(PWA_RT_CTRL, 8'h01, 8'h01);
    io_w(PWA_RT_CTRL, 8'h03);
    io_chk(PWA_RT_CTRL, 8'h01, 8'h00);
    tick(3);
    pin_chk(2'b01);
    test_done("global");
    io_w(PWA_RT_GPIO_POL_BASE, 8'h02);
    io_w(PWA_RT_GPIO_EITHER_EDGE_TRIGGER_BASE, 8'h04);
    gpio_in[2:1] = 2'b11;
    tick(3);
    io_chk(7'h02, 8'h06, 8'h04);
    io_w(7'h02, 8'h04);
    gpio_in[2:1] = 2'b00;
    tick(3);
    io_chk(7'h02, 8'h06, 8'h06);
    io_w(7'h02, 8'h06);
    test_done("gpio");
    {ring_a_n, ring_b_n, kbd_data, mouse_data, fan_ev, wdt_ev, device_irq} = {6'b000011, 8'h08};
    tick(3);
    io_chk(7'h01, 8'hff, 8'h5f);
    io_chk(7'h06, 8'hff, 8'h08);
    io_w(7'h01, 8'hff);
    io_w(7'h06, 8'hff);
    io_chk(7'h01, 8'hff, 8'h00);
    test_done("sources");
    io_w(PWA_RT_EDGE_SEL, 8'h02);
    pin_b = 1'b0;
    pin_a = 1'b0;
    tick(3);
    io_chk(7'h07, 8'hc0, 8'hc0);
    chk({7'h00, smi}, 8'h01, "port pin smi");
    io_w(7'h07, 8'hc0);
    tick(2);
    chk({7'h00, smi}, 8'h00, "port pin smi");
    pin_b = 1'b1;
    pin_a = 1'b1;
    tick(3);
    io_chk(7'h07, 8'hc0, 8'h80);
    io_w(7'h07, 8'hc0);
    io_w(PWA_RT_EDGE_SEL, 8'h04);
    io_w(7'h07, 8'hc0);
    pin_a = 1'b0;
    tick(3);
    io_chk(7'h07, 8'hc0, 8'h00);
    pin_a = 1'b1;
    tick(3);
    io_chk(7'h07, 8'hc0, 8'h40);
    io_w(7'h07, 8'hc0);
    test_done("port pins");
    io_w(PWA_RT_SHARED_PIN_CTRL, 8'h02);
    io_w(7'h0e, 8'h01);
    tick(2);
    pin_chk(2'b00);
    device_irq = 8'h09;
    tick(5);
    pin_chk(2'b10);
    io_w(7'h06, 8'hff);
    io_w(PWA_RT_CTRL, 8'h03);
    io_w(PWA_RT_SHARED_PIN_CTRL, 8'h80);
    tick(3);
    pin_chk(2'b01);
    test_done("pin mode");
    io_w(PWA_RT_WAKE_KEY_CODE, 8'h1c);
    io_w(7'h09, 8'h20);
    send_frame(8'h1c, 1'b1);
    io_chk(7'h01, 8'h20, 8'h20);
    pin_chk(2'b00);
    io_w(7'h01, 8'hff);
    io_w(PWA_RT_CTRL, 8'h03);
    send_frame(8'h1c, 1'b0);
    io_chk(7'h01, 8'h20, 8'h00);
    send_frame(8'h2a, 1'b1);
    io_chk(7'h01, 8'h20, 8'h00);
    cfg_w(PWA_CFG_SLOW_CLOCK, 8'h02);
    cfg_chk(PWA_CFG_SLOW_CLOCK, 8'h02);
    send_frame(8'h1c, 1'b1);
    io_chk(7'h01, 8'h20, 8'h00);
    cfg_w(PWA_CFG_SLOW_CLOCK, 8'h00);
    main_power = 1'b0;
    send_frame(8'h1c, 1'b1);
    io_chk(7'h01, 8'h20, 8'h00);
    main_power = 1'b1;
    send_frame(8'h1c, 1'b1);
    io_chk(7'h01, 8'h20, 8'h20);
    io_w(7'h01, 8'hff);
    cfg_w(PWA_CFG_SLOW_CLOCK, 8'h01);
    main_power = 1'b0;
    send_frame(8'h1c, 1'b1);
    io_chk(7'h01, 8'h20, 8'h20);
    main_power = 1'b1;
    test_done("key match");
    complete_run();
  end
endmodule
